/* design/pwm_update_pkg.sv */
// Shared constants and types for the PWM update and repetition control block and its controller
// Notes on behaviour
// RULE1 - Compares go active only when repetition expires; the code also transfers them on the FFh resync write and at clock enable start
// RULE2 - Edge mode: transfer once every N cycles
// RULE3 - Center mode: decrement at overflow and underflow
// RULE4 - Repetition counter reloads itself after expiring
// RULE5 - Update flag and interrupt raised with update
// RULE6 - Debug pin mirrors every update event
// RULE7 - Status write FFh clears counter, forces update
// RULE8 - FFh write touches only the update flag
// RULE9 - Resync: preload, write FFh, then write 7Fh
// RULE10 - Never set both ratio flags in switched mode
// RULE11 - Clock enable low holds counter at zero
// RULE12 - Clock enable set starts counter, forces update
// RULE13 - Write compare low then high before enabling
// RULE14 - Stop motor before halt or wait
// RULE15 - Wait mode: keep running, interrupts wake processor
// RULE16 - Halt mode: frozen, no wake from here
// RULE17 - Interrupt needs enable bit and clear global mask
// RULE18 - Requests routed onto three interrupt vectors
// RULE19 - Update flag set once compares transferred
// RULE20 - Update event clears duty overflow extension bits
// RULE21 - Reads return preload values, not active ones
package pwm_update_pkg;
  // Device register addresses on the 8-bit register port
  localparam logic [3:0] ADDR_REPETITION = 4'h0;
  localparam logic [3:0] ADDR_PWM_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_CMP_BASE = 4'h2;
  localparam logic [3:0] ADDR_CMP_LAST = 4'h9;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hA;
  localparam logic [3:0] ADDR_EVENT_STATUS = 4'hB;
  localparam logic [3:0] ADDR_CONTROL_A = 4'hC;
  localparam logic [3:0] ADDR_EXTRA_EVENTS = 4'hD;
  // Field positions
  localparam int CENTER_MODE_BIT = 0;
  localparam int BYTE_MODE_BIT = 1;
  localparam int OVF_U_BIT = 4;
  localparam int CLOCK_ENABLE_BIT = 6;
  localparam int AUTOSWITCH_BIT = 2;
  localparam int UPDATE_FLAG_BIT = 7;
  localparam int RATIO_UP_BIT = 6;
  localparam int RATIO_DOWN_BIT = 5;
  localparam int SPEED_ERROR_BIT = 0;
  localparam int SAMPLING_OUT_BIT = 1;
  localparam int SPEED_ERROR_EN_BIT = 6;
  localparam int SAMPLING_OUT_EN_BIT = 4;
  // Special values and resets
  localparam logic [7:0] RESYNC_VALUE = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] COUNTER_RESET = 12'h000;
  localparam int NUM_COMPARES = 4;
  localparam int NUM_EVENTS = 9;
  // Controller APB map
  localparam logic [7:0] APB_COMMAND = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_CONTROL = 8'h08;
  localparam int CMD_GO_BIT = 31;
  localparam int CMD_WRITE_BIT = 12;
  typedef enum logic [1:0] {HOST_IDLE, HOST_ISSUE, HOST_WAIT, HOST_CAPTURE} host_state_type;
endpackage : pwm_update_pkg

/* design/pwm_update_if.sv */
// Link between the PWM update block and its controlling party
interface pwm_update_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic       reg_sel;      // One-cycle register access strobe
  logic       reg_wr;       // Write when high, read when low
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;    // Valid the cycle after a read strobe
  logic [2:0] irq;          // Three interrupt vectors
  logic       wake;         // Wake from wait mode
  logic       update_dbg;   // Mirror of update events
  logic       global_mask;  // Processor global interrupt mask
  logic       wait_mode;
  logic       halt_mode;

  modport device (
    input  pclk, presetn, reg_sel, reg_wr, reg_addr, reg_wdata, global_mask, wait_mode, halt_mode,
    output reg_rdata, irq, wake, update_dbg
  );
  modport host (
    input  pclk, presetn, reg_rdata, irq, wake, update_dbg,
    output reg_sel, reg_wr, reg_addr, reg_wdata, global_mask, wait_mode, halt_mode
  );
endinterface : pwm_update_if

/* design/pwm_update_device.sv */
// PWM counter, repetition down-counter, preload transfer and event flags
//
// Our own choices: the register offsets and register access over APB.
module pwm_update_device (
  // Link
  pwm_update_if.device             link,
  // Clock enable
  input  wire logic                ce,
  // Other event pulses: ratio up, ratio down, speed error, emergency stop,
  // current limit, zero cross, demag end, commutation, sampling out
  input  wire logic [8:0]          event_in,
  // Outputs to the channel manager
  output logic      [11:0]         pwm_counter,
  output logic      [15:0]         carrier_period_compare,
  output logic      [15:0]         phase_u_compare,
  output logic      [15:0]         phase_v_compare,
  output logic      [15:0]         phase_w_compare,
  output logic      [2:0]          duty_overflow_extension,
  output logic                     center_mode,
  output logic                     byte_mode
);
  localparam int NUM_COMPARES_L = pwm_update_pkg::NUM_COMPARES;

  // Preload and control storage
  logic [7:0]  repetition_count_reg;
  logic [7:0]  pwm_control_reg;
  logic [7:0]  cmp_lo_reg [NUM_COMPARES_L];
  logic [7:0]  cmp_hi_reg [NUM_COMPARES_L];
  logic [3:0]  pending_reg;
  logic [7:0]  irq_enable_reg;
  logic [7:0]  motor_event_status_reg;
  logic [7:0]  control_a_reg;
  logic [7:0]  extra_events_reg;
  // Active state
  logic [15:0] act_reg [NUM_COMPARES_L];
  logic [7:0]  rep_act_reg;
  logic [7:0]  rep_cnt_reg;
  logic [11:0] cnt_reg;
  logic        down_reg;
  logic        clk_en_d_reg;
  logic [7:0]  rdata_reg;
  logic [2:0]  irq_reg;
  logic        wake_reg;
  logic        dbg_reg;

  // Compare address decoding
  function automatic logic [1:0] cmp_index(input logic [3:0] a);
    logic [3:0] off;
    off = a - pwm_update_pkg::ADDR_CMP_BASE;
    cmp_index = off[2:1];
  endfunction : cmp_index

  function automatic logic cmp_is_high(input logic [3:0] a);
    logic [3:0] off;
    off = a - pwm_update_pkg::ADDR_CMP_BASE;
    cmp_is_high = off[0];
  endfunction : cmp_is_high

  // Access decoding
  wire       run       = ce & ~link.halt_mode;  // Halt freezes every register [RULE16]
  wire       wr        = link.reg_sel & link.reg_wr;
  wire       rd        = link.reg_sel & ~link.reg_wr;
  wire       wr_cmp    = wr && link.reg_addr >= pwm_update_pkg::ADDR_CMP_BASE
                            && link.reg_addr <= pwm_update_pkg::ADDR_CMP_LAST;
  wire [1:0] wr_idx    = cmp_index(link.reg_addr);
  wire       wr_high   = cmp_is_high(link.reg_addr);
  wire       wr_status = wr && link.reg_addr == pwm_update_pkg::ADDR_EVENT_STATUS;
  wire       resync    = wr_status && link.reg_wdata == pwm_update_pkg::RESYNC_VALUE;  // [RULE7]
  wire       clk_en    = control_a_reg[pwm_update_pkg::CLOCK_ENABLE_BIT];
  wire       autosw    = control_a_reg[pwm_update_pkg::AUTOSWITCH_BIT];
  wire       center    = pwm_control_reg[pwm_update_pkg::CENTER_MODE_BIT];
  wire       start     = clk_en & ~clk_en_d_reg;  // Enabling the clock forces an update [RULE12]

  // Counter turning points
  wire [11:0] top       = act_reg[0][11:0];
  wire        at_top    = clk_en && cnt_reg == top && !(center && down_reg);
  wire        at_bottom = clk_en && center && down_reg && cnt_reg == pwm_update_pkg::COUNTER_RESET;
  wire        turn      = at_top | at_bottom;  // Both edges count in center mode [RULE3]
  wire        expired   = rep_cnt_reg == 8'h00;
  wire        upd       = (turn & expired) | resync | start;  // [RULE1]
  wire [7:0]  rep_new   = start ? repetition_count_reg : rep_act_reg;
  wire [7:0]  rep_load  = (rep_new == 8'h00) ? 8'h00 : rep_new - 8'h01;  // N events per update [RULE2]

  // Event flags: hardware set wins over software clear
  wire [7:0] ev_status = {upd, event_in[0], event_in[1], event_in[4], event_in[3],
                          event_in[5], event_in[6], event_in[7]};
  wire [7:0] ev_extra  = {6'h00, event_in[8], event_in[2]};
  wire [7:0] sw_status = resync ? (motor_event_status_reg | 8'h80)  // Only the update flag moves [RULE8]
                       : !wr_status ? motor_event_status_reg
                       : autosw ? (motor_event_status_reg & link.reg_wdata)
                       : ((motor_event_status_reg & link.reg_wdata & 8'h9F) | (link.reg_wdata & 8'h60));
  wire       wr_extra  = wr && link.reg_addr == pwm_update_pkg::ADDR_EXTRA_EVENTS;
  wire [7:0] sw_extra  = wr_extra ? {link.reg_wdata[7:2],
                                     extra_events_reg[1:0] & link.reg_wdata[1:0]} : extra_events_reg;

  // Interrupt gating per vector
  wire [7:0] st_pend = motor_event_status_reg & irq_enable_reg;
  wire       ratio_en = irq_enable_reg[5];
  wire [1:0] ex_pend = extra_events_reg[1:0] &
                       {extra_events_reg[pwm_update_pkg::SAMPLING_OUT_EN_BIT],
                        irq_enable_reg[pwm_update_pkg::SPEED_ERROR_EN_BIT]};
  wire [2:0] vec_req = {
    st_pend[7] | ex_pend[1],
    ((motor_event_status_reg[6] | motor_event_status_reg[5]) & ratio_en) | ex_pend[0],
    |st_pend[4:0]
  };
  wire [2:0] irq_next = link.global_mask ? 3'h0 : vec_req;  // [RULE17] [RULE18]

  // Read mux returns preload values
  wire [7:0] rd_cmp  = cmp_is_high(link.reg_addr) ? cmp_hi_reg[cmp_index(link.reg_addr)]
                                                  : cmp_lo_reg[cmp_index(link.reg_addr)];
  wire [7:0] rd_next = link.reg_addr == pwm_update_pkg::ADDR_REPETITION   ? repetition_count_reg
                     : link.reg_addr == pwm_update_pkg::ADDR_PWM_CONTROL  ? pwm_control_reg
                     : link.reg_addr <= pwm_update_pkg::ADDR_CMP_LAST     ? rd_cmp  // [RULE21]
                     : link.reg_addr == pwm_update_pkg::ADDR_IRQ_ENABLE   ? irq_enable_reg
                     : link.reg_addr == pwm_update_pkg::ADDR_EVENT_STATUS ? motor_event_status_reg
                     : link.reg_addr == pwm_update_pkg::ADDR_CONTROL_A    ? control_a_reg
                     : link.reg_addr == pwm_update_pkg::ADDR_EXTRA_EVENTS ? extra_events_reg
                     : 8'h00;

  // Control and preload registers
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      repetition_count_reg   <= pwm_update_pkg::REG_RESET;
      pwm_control_reg        <= pwm_update_pkg::REG_RESET;
      irq_enable_reg         <= pwm_update_pkg::REG_RESET;
      control_a_reg          <= pwm_update_pkg::REG_RESET;
      motor_event_status_reg <= pwm_update_pkg::REG_RESET;
      extra_events_reg       <= pwm_update_pkg::REG_RESET;
      rdata_reg              <= pwm_update_pkg::REG_RESET;
    end else if (run) begin
      if (wr && link.reg_addr == pwm_update_pkg::ADDR_REPETITION) repetition_count_reg <= link.reg_wdata;
      if (wr && link.reg_addr == pwm_update_pkg::ADDR_PWM_CONTROL) pwm_control_reg <= link.reg_wdata;
      else if (upd) pwm_control_reg[pwm_update_pkg::OVF_U_BIT +: 3] <= 3'h0;  // [RULE20]
      if (wr && link.reg_addr == pwm_update_pkg::ADDR_IRQ_ENABLE) irq_enable_reg <= link.reg_wdata;
      if (wr && link.reg_addr == pwm_update_pkg::ADDR_CONTROL_A) control_a_reg <= link.reg_wdata;
      motor_event_status_reg <= sw_status | ev_status;  // Update flag set with transfer [RULE5] [RULE19]
      extra_events_reg       <= sw_extra | ev_extra;
      if (rd) rdata_reg <= rd_next;
    end
  end

  // Compare preload bytes; a high-byte write completes a 16-bit value
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      pending_reg <= 4'h0;
      for (int i = 0; i < NUM_COMPARES_L; i++) begin
        cmp_lo_reg[i] <= pwm_update_pkg::REG_RESET;
        cmp_hi_reg[i] <= pwm_update_pkg::REG_RESET;
      end
    end else if (run && wr_cmp) begin
      if (wr_high) cmp_hi_reg[wr_idx] <= link.reg_wdata;
      else cmp_lo_reg[wr_idx] <= link.reg_wdata;
      pending_reg[wr_idx] <= ~wr_high & ~pwm_control_reg[pwm_update_pkg::BYTE_MODE_BIT];  // [RULE13]
    end
  end

  // Preload to active transfer on update events
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      rep_act_reg <= pwm_update_pkg::REG_RESET;
      for (int i = 0; i < NUM_COMPARES_L; i++) act_reg[i] <= 16'h0000;
    end else if (run && upd) begin
      rep_act_reg <= repetition_count_reg;
      for (int i = 0; i < NUM_COMPARES_L; i++) begin
        if (!pending_reg[i]) act_reg[i] <= {cmp_hi_reg[i], cmp_lo_reg[i]};  // [RULE1]
      end
    end
  end

  // PWM counter and repetition down-counter
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      cnt_reg      <= pwm_update_pkg::COUNTER_RESET;
      down_reg     <= 1'b0;
      rep_cnt_reg  <= pwm_update_pkg::REG_RESET;
      clk_en_d_reg <= 1'b0;
    end else if (run) begin
      clk_en_d_reg <= clk_en;
      if (!clk_en || resync) begin
        cnt_reg  <= pwm_update_pkg::COUNTER_RESET;  // [RULE11] [RULE7]
        down_reg <= 1'b0;
      end else if (at_top && !center) cnt_reg <= pwm_update_pkg::COUNTER_RESET;
      else if (at_top) begin
        down_reg <= 1'b1;
        cnt_reg  <= (top == 12'h000) ? 12'h000 : cnt_reg - 12'h001;
      end else if (at_bottom) begin
        down_reg <= 1'b0;
        cnt_reg  <= cnt_reg + 12'h001;
      end else if (down_reg) cnt_reg <= cnt_reg - 12'h001;
      else cnt_reg <= cnt_reg + 12'h001;
      if (upd) rep_cnt_reg <= rep_load;  // Auto-reload [RULE4]
      else if (turn) rep_cnt_reg <= rep_cnt_reg - 8'h01;  // [RULE2] [RULE3]
    end
  end

  // Interrupt vectors, wake and debug mirror
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      irq_reg  <= 3'h0;
      wake_reg <= 1'b0;
      dbg_reg  <= 1'b0;
    end else if (run) begin
      irq_reg  <= irq_next;
      wake_reg <= link.wait_mode & |vec_req;  // Wait mode keeps running [RULE15]
      dbg_reg  <= upd;  // [RULE6]
    end
  end

  // Output drive
  assign link.reg_rdata          = rdata_reg;
  assign link.irq                = irq_reg;
  assign link.wake               = wake_reg;
  assign link.update_dbg         = dbg_reg;
  assign pwm_counter             = cnt_reg;
  assign carrier_period_compare  = act_reg[0];
  assign phase_u_compare         = act_reg[1];
  assign phase_v_compare         = act_reg[2];
  assign phase_w_compare         = act_reg[3];
  assign duty_overflow_extension = pwm_control_reg[pwm_update_pkg::OVF_U_BIT +: 3];
  assign center_mode             = center;
  assign byte_mode               = pwm_control_reg[pwm_update_pkg::BYTE_MODE_BIT];
endmodule : pwm_update_device

/* design/pwm_update_host.sv */
// Controller end: APB slave that issues device register accesses
module pwm_update_host (
  // Link
  pwm_update_if.host          link,
  // Clock enable
  input  wire logic           ce,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr
);
  pwm_update_pkg::host_state_type state_reg;
  logic [12:0] cmd_reg;
  logic [7:0]  rdata_hold_reg;
  logic [2:0]  ctrl_reg;
  logic        sel_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // APB decoding
  wire access  = psel & penable & ~pready_reg;
  wire hit_cmd = paddr == pwm_update_pkg::APB_COMMAND;
  wire hit_st  = paddr == pwm_update_pkg::APB_STATUS;
  wire hit_ctl = paddr == pwm_update_pkg::APB_CONTROL;
  wire mapped  = hit_cmd | hit_st | hit_ctl;
  wire busy    = state_reg != pwm_update_pkg::HOST_IDLE;
  wire go      = access & pwrite & hit_cmd & pwdata[pwm_update_pkg::CMD_GO_BIT] & ~busy;
  wire [31:0] status_word = {11'h000, link.update_dbg, link.wake, link.irq, 5'h00,
                             rdata_hold_reg, 2'h0, busy};
  wire [31:0] rd_word = hit_cmd ? {19'h00000, cmd_reg}
                      : hit_st  ? status_word
                      : hit_ctl ? {29'h00000000, ctrl_reg}
                      : 32'h00000000;

  // APB answer: one wait state
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg    <= 3'h0;
    end else if (ce) begin
      pready_reg  <= access;
      pslverr_reg <= access & ~mapped;
      if (access && !pwrite) prdata_reg <= rd_word;
      if (access && pwrite && hit_ctl) ctrl_reg <= pwdata[2:0];  // [RULE14]
    end
  end

  // Device access sequencer
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_reg      <= pwm_update_pkg::HOST_IDLE;
      cmd_reg        <= 13'h0000;
      sel_reg        <= 1'b0;
      rdata_hold_reg <= 8'h00;
    end else if (ce) begin
      case (state_reg)
        pwm_update_pkg::HOST_IDLE: begin
          if (go) begin
            cmd_reg   <= pwdata[12:0];  // Order of writes is software's duty [RULE9] [RULE10] [RULE13]
            sel_reg   <= 1'b1;
            state_reg <= pwm_update_pkg::HOST_ISSUE;
          end
        end
        pwm_update_pkg::HOST_ISSUE: begin
          sel_reg   <= 1'b0;
          state_reg <= pwm_update_pkg::HOST_WAIT;
        end
        pwm_update_pkg::HOST_WAIT: state_reg <= pwm_update_pkg::HOST_CAPTURE;
        pwm_update_pkg::HOST_CAPTURE: begin
          if (!cmd_reg[pwm_update_pkg::CMD_WRITE_BIT]) rdata_hold_reg <= link.reg_rdata;
          state_reg <= pwm_update_pkg::HOST_IDLE;
        end
        default: state_reg <= pwm_update_pkg::HOST_IDLE;
      endcase
    end
  end

  // Output drive
  assign link.reg_sel     = sel_reg;
  assign link.reg_wr      = cmd_reg[pwm_update_pkg::CMD_WRITE_BIT];
  assign link.reg_addr    = cmd_reg[11:8];
  assign link.reg_wdata   = cmd_reg[7:0];
  assign link.global_mask = ctrl_reg[0];
  assign link.wait_mode   = ctrl_reg[1];
  assign link.halt_mode   = ctrl_reg[2];
  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
endmodule : pwm_update_host

/* testbench/pwm_update_monitor.sv */
// Concurrent checks on the link between the PWM update device and its controller
module pwm_update_monitor (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Register access
  input wire logic       reg_sel,
  input wire logic       reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Events and modes
  input wire logic [2:0] irq,
  input wire logic       wake,
  input wire logic       update_dbg,
  input wire logic       global_mask,
  input wire logic       wait_mode,
  input wire logic       halt_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic enable_shadow_reg;
  logic update_en_reg;
  wire  taken_wr = reg_sel && reg_wr && !halt_mode;
  wire  read_req = reg_sel && !reg_wr && !halt_mode;
  // Shadows of the clock enable and update enable bits as written over the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_shadow_reg <= 1'b0;
      update_en_reg     <= 1'b0;
    end else if (taken_wr && reg_addr == pwm_update_pkg::ADDR_CONTROL_A) begin
      enable_shadow_reg <= reg_wdata[pwm_update_pkg::CLOCK_ENABLE_BIT];
    end else if (taken_wr && reg_addr == pwm_update_pkg::ADDR_IRQ_ENABLE) begin
      update_en_reg <= reg_wdata[7];
    end
  end
  sequence resync_write;
    taken_wr && reg_addr == pwm_update_pkg::ADDR_EVENT_STATUS && reg_wdata == pwm_update_pkg::RESYNC_VALUE;
  endsequence
  sequence enable_rise;
    !enable_shadow_reg ##1 enable_shadow_reg;
  endsequence
  chk_resync_update: assert property (resync_write |-> ##[1:3] update_dbg)
    else $error("no update pulse after resync write");
  chk_enable_update: assert property (enable_rise |-> ##[1:4] update_dbg)
    else $error("no update pulse after clock enable");
  chk_resync_irq_raise: assert property (resync_write ##1 (update_en_reg && !global_mask) [*4] |-> irq[2])
    else $error("resync did not request update interrupt");
  chk_mask_blocks_irq: assert property (global_mask [*2] |-> irq == 3'h0)
    else $error("interrupt requested while masked");
  chk_wake_wait_only: assert property (!wait_mode [*2] |-> !wake)
    else $error("wake raised outside wait mode");
  chk_halt_regs_frozen: assert property (halt_mode [*2] |-> $stable(reg_rdata))
    else $error("read data changed in halt");
  chk_rdata_holds: assert property (!read_req |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (read_req && reg_addr > 4'hD |=> reg_rdata == 8'h00)
    else $error("unmapped device address read nonzero");
endmodule : pwm_update_monitor

/* testbench/pwm_update_repetition_control_bench.sv */
// Self-checking bench for the PWM update device driven through its APB controller
module pwm_update_repetition_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] addr; logic [7:0] wdata; logic [7:0] rexp;} row_type;
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic [8:0]  event_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] pwm_counter;
  logic [15:0] carrier;
  logic [15:0] phase_u;
  logic [2:0]  ovf_ext;
  logic [31:0] r32;
  logic        err;
  logic [7:0]  q;
  int          fail_count;
  int          check_count;
  int          cycle_count;
  int          p;
  int          g;
  row_type rows[0:13] = '{'{4'h0, 8'h05, 8'h05}, '{4'h1, 8'h71, 8'h71}, '{4'h2, 8'h11, 8'h11},
    '{4'h3, 8'h22, 8'h22}, '{4'h4, 8'h33, 8'h33}, '{4'h5, 8'h44, 8'h44}, '{4'h6, 8'h55, 8'h55},
    '{4'h7, 8'h66, 8'h66}, '{4'h8, 8'h77, 8'h77}, '{4'h9, 8'h88, 8'h88}, '{4'hA, 8'h80, 8'h80},
    '{4'hC, 8'h04, 8'h04}, '{4'hD, 8'h10, 8'h10}, '{4'hE, 8'h5A, 8'h00}};
  pwm_update_if link (.pclk(pclk), .presetn(presetn));
  pwm_update_device u_pwm_update_device (.link(link), .ce(ce), .event_in(event_in), .pwm_counter(pwm_counter),
    .carrier_period_compare(carrier), .phase_u_compare(phase_u), .phase_v_compare(), .phase_w_compare(),
    .duty_overflow_extension(ovf_ext), .center_mode(), .byte_mode());
  pwm_update_host u_pwm_update_host (.link(link), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pwm_update_monitor u_pwm_update_monitor (.pclk(pclk), .presetn(presetn), .reg_sel(link.reg_sel),
    .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .irq(link.irq), .wake(link.wake), .update_dbg(link.update_dbg), .global_mask(link.global_mask),
    .wait_mode(link.wait_mode), .halt_mode(link.halt_mode));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // One APB transfer: setup, then access held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Device register access through the controller, polling busy
  task dev(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] rd);
    logic [31:0] cmd;
    logic [31:0] r;
    logic        e;
    cmd = {1'b1, 18'h00000, wr, a, d};
    apb(1'b1, pwm_update_pkg::APB_COMMAND, cmd, r, e);
    r = 32'h0000_0001;
    while (r[0] === 1'b1) apb(1'b0, pwm_update_pkg::APB_STATUS, 32'h0000_0000, r, e);
    rd = r[10:3];
  endtask : dev
  function automatic logic hit(input logic use_dbg);
    return use_dbg ? (link.update_dbg === 1'b1) : (pwm_counter === 12'h000);
  endfunction : hit
  // Cycles between two consecutive counter-zero or update pulses
  task gap(input logic use_dbg, output int n);
    n = 0;
    do @(negedge pclk); while (!hit(use_dbg));
    do begin
      @(negedge pclk);
      n++;
    end while (!hit(use_dbg));
  endtask : gap
  // Hang guard
  always @(posedge pclk) begin
    cycle_count++;
    if (cycle_count == 30000) begin
      fail_count++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    {presetn, ce, event_in, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ce <= 1'b1;
    apb(1'b0, pwm_update_pkg::APB_STATUS, 32'h0000_0000, r32, err);
    check(r32, 32'h0000_0000);
    check({20'h00000, pwm_counter}, 32'h0000_0000);
    foreach (rows[i]) begin
      dev(1'b1, rows[i].addr, rows[i].wdata, q);
      dev(1'b0, rows[i].addr, 8'h00, q);
      check({24'h000000, q}, {24'h000000, rows[i].rexp});
    end
    apb(1'b1, 8'h0C, 32'h0000_0001, r32, err);
    check({31'h0, err}, 32'h0000_0001);
    // Edge mode, repeat every third period, then enable the clock
    dev(1'b1, 4'h0, 8'h03, q);
    dev(1'b1, 4'h1, 8'h00, q);
    dev(1'b1, 4'h2, 8'h40, q);
    dev(1'b1, 4'h3, 8'h00, q);
    check({20'h00000, pwm_counter}, 32'h0000_0000);
    dev(1'b1, 4'hC, 8'h44, q);
    check({16'h0000, carrier}, 32'h0000_0040);
    check({16'h0000, phase_u}, 32'h0000_4433);
    dev(1'b0, 4'hB, 8'h00, q);
    check({24'h000000, q}, 32'h0000_0080);
    check({31'h0, link.irq[2]}, 32'h0000_0001);
    gap(1'b1, g);
    gap(1'b0, p);
    gap(1'b1, g);
    check(32'(g), 32'(3 * p));
    gap(1'b1, g);
    check(32'(g), 32'(3 * p));
    // Center mode: updates counted at both ends of the period
    dev(1'b1, 4'h1, 8'h01, q);
    repeat (2) gap(1'b1, g);
    gap(1'b0, p);
    gap(1'b1, g);
    check(32'(2 * g), 32'(3 * p));
    // Global mask, then wait mode with a pending enabled event
    apb(1'b1, pwm_update_pkg::APB_CONTROL, 32'h0000_0001, r32, err);
    repeat (3) @(negedge pclk);
    check({29'h0, link.irq}, 32'h0000_0000);
    apb(1'b1, pwm_update_pkg::APB_CONTROL, 32'h0000_0002, r32, err);
    repeat (3) @(negedge pclk);
    check({31'h0, link.wake}, 32'h0000_0001);
    // Resync with the clock stopped
    dev(1'b1, 4'hC, 8'h04, q);
    repeat (3) @(negedge pclk);
    check({20'h00000, pwm_counter}, 32'h0000_0000);
    dev(1'b1, 4'hB, 8'h00, q);
    @(posedge pclk);
    event_in <= 9'h010;
    @(posedge pclk);
    event_in <= 9'h000;
    dev(1'b1, 4'h2, 8'h80, q);
    dev(1'b1, 4'h3, 8'h00, q);
    dev(1'b1, 4'h1, 8'h70, q);
    check({29'h0, ovf_ext}, 32'h0000_0007);
    dev(1'b1, 4'hB, 8'hFF, q);
    check({16'h0000, carrier}, 32'h0000_0080);
    check({20'h00000, pwm_counter}, 32'h0000_0000);
    check({29'h0, ovf_ext}, 32'h0000_0000);
    dev(1'b0, 4'hB, 8'h00, q);
    check({24'h000000, q}, 32'h0000_0090);
    check({31'h0, link.irq[2]}, 32'h0000_0001);
    dev(1'b1, 4'hB, 8'h7F, q);
    dev(1'b0, 4'hB, 8'h00, q);
    check({24'h000000, q}, 32'h0000_0010);
    // Switched mode: software sets one ratio flag, never both
    dev(1'b1, 4'hC, 8'h00, q);
    dev(1'b1, 4'hB, 8'hDF, q);
    dev(1'b0, 4'hB, 8'h00, q);
    check({24'h000000, q}, 32'h0000_0050);
    // Halt: a write is not taken
    apb(1'b1, pwm_update_pkg::APB_CONTROL, 32'h0000_0004, r32, err);
    dev(1'b1, 4'h0, 8'h77, q);
    apb(1'b1, pwm_update_pkg::APB_CONTROL, 32'h0000_0000, r32, err);
    dev(1'b0, 4'h0, 8'h00, q);
    check({24'h000000, q}, 32'h0000_0003);
    complete_run();
  end
endmodule : pwm_update_repetition_control_bench
